// >>> hw/touch_sense_result_logic.v
// touch scan sequencer, decisions, slider, gpio, event flags, bus slave
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
`include "touch_regs.vh"

// Function
// - six-bit release margin sets untouch level
// - gap band keeps touch, no event
// - eight inputs switched one at a time
// - default 1024 samples averaged per input
// - decimation selectable 128, 256, 512, 1024, 2048
// - conversion time scales with decimation rate
// - scan period equals conversion times active count
// - only connected inputs converted, floating skipped
// - result relative to per-sensor baseline
// - 2x interpolated slider and wheel positions
// - status bit one on touch, zero untouch
// - pin asserts after status update on events
// - strap inverts notify pin polarity
// - status read releases pin, clears events
// - gpio flag bit 15, touches below
// - register assigns channels to slider or wheel
// - slider flag, direction, five-bit location
// - two-bit gpio function, reset output low
// - push-pull active-low notify pin default
// - pattern zero-one selects gpio input
// - gpio clears only when trigger ended
module touch_sense_result_logic #(
  parameter NCH = 8,
  parameter SAMPLE_CYCLES = `SAMPLE_CYCLES
) (
  input wire clk,
  input wire arst_n,
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output reg [2:0] conv_chan_sel,
  output reg conv_connect,
  output reg conv_sample,
  input wire conv_bit,
  input wire notify_invert_strap,
  output reg event_notify_pin,
  input wire gpio_in,
  output reg gpio_out,
  output reg gpio_oe
);
  localparam ST_IDLE = 3'b001;
  localparam ST_CONV = 3'b010;
  localparam ST_STORE = 3'b100;

  reg [2:0] state_r;
  reg [2:0] ch_r;
  reg [11:0] div_r;
  reg [11:0] nsamp_r;
  reg [11:0] ones_r;
  reg ack_r;
  reg [15:0] gpio_cfg_r;
  reg [7:0] scan_en_r;
  reg [2:0] dec_sel_r;
  reg [15:0] thresh_r;
  reg [5:0] margin_r;
  reg [8:0] slider_assign_r;
  reg [15:0] base_r [0:NCH-1];
  reg [15:0] result_r [0:NCH-1];
  reg [7:0] touch_stat_r;
  reg touch_pend_r;
  reg slider_flag_r;
  reg gpio_flag_r;
  reg gpio_prev_r;
  reg inv_r;
  reg strap_done_r;
  reg [4:0] loc_r;
  reg dir_r;
  reg any_r;
  reg [NCH-1:0] upd_r;
  reg [2:0] dec_eff;
  reg [11:0] last_samp;
  reg [15:0] avg;
  reg [4:0] loc;
  reg any_sl;
  reg gpio_cond;
  reg gpio_edge;
  reg [3:0] cnt;
  reg found;
  reg cand;
  reg prev_t;
  reg first_t;
  wire [7:0] idx;
  wire wr_fire;
  wire rd_fire;
  wire tick;
  wire [NCH-1:0] touched;
  wire [NCH-1:0] ev_t;
  wire [NCH-1:0] ev_u;
  wire [NCH-1:0] ev_any;
  wire notify_active;
  wire [2:0] trig;
  integer i;
  integer ri;
  integer fi;
  integer bi;

  assign idx = avs_address[9:2];
  assign trig = gpio_cfg_r[`GPIO_TRIG_LSB+2:`GPIO_TRIG_LSB];
  assign ev_any = ev_t | ev_u;

  // one wait state: writes taken at the edge where waitrequest is low, reads at the wait edge before it
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign wr_fire = avs_write && ack_r;
  // status clears at the edge that snapshots it, so an event landing
  // between snapshot and completion is kept rather than lost
  assign rd_fire = avs_read && !ack_r && (idx == `EVENT_FLAGS_IDX);

  // byte-lane merge for 16-bit registers
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] wd;
    input [3:0] be;
    begin
      merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    end
  endfunction

  // next connected input after cur, cyclic
  function [2:0] next_ch;
    input [7:0] en;
    input [2:0] cur;
    reg [2:0] k;
    reg hit;
    integer j;
    begin
      next_ch = cur;
      hit = 1'b0;
      for (j = 1; j <= 8; j = j + 1) begin
        k = cur + j[2:0];
        if (!hit && en[k]) begin
          next_ch = k;
          hit = 1'b1;
        end
      end
    end
  endfunction

  // decimation select; unknown codes fall back to the default
  always @* begin
    dec_eff = (dec_sel_r > `DEC_SEL_2048) ? `DEC_SEL_RST : dec_sel_r;
    last_samp = (12'h080 << dec_eff) - 12'h001;
    // scale the ones count to a common 2048-sample range
    avg = {4'h0, ones_r} << (`DEC_SEL_2048 - dec_eff);
  end

  // sample-rate divider; one conversion is the sample count times 2 us
  assign tick = (div_r == SAMPLE_CYCLES - 1);

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      div_r <= 12'h000;
    else if (tick)
      div_r <= 12'h000;
    else
      div_r <= div_r + 12'h001;
  end

  // sequencer: back-to-back conversions so the scan period is
  // conversion time times the number of connected inputs
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
      ch_r <= 3'h7;
      nsamp_r <= 12'h000;
      ones_r <= 12'h000;
      upd_r <= {NCH{1'b0}};
      conv_chan_sel <= 3'h0;
      conv_connect <= 1'b0;
      conv_sample <= 1'b0;
      for (ri = 0; ri < NCH; ri = ri + 1)
        result_r[ri] <= 16'h0000;
    end else begin
      upd_r <= {NCH{1'b0}};
      conv_sample <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          conv_connect <= 1'b0;
          nsamp_r <= 12'h000;
          ones_r <= 12'h000;
          if (scan_en_r != 8'h00) begin
            ch_r <= next_ch(scan_en_r, ch_r);
            conv_chan_sel <= next_ch(scan_en_r, ch_r);
            conv_connect <= 1'b1;
            state_r <= ST_CONV;
          end
        end
        ST_CONV: begin
          // an input made floating mid-conversion is dropped at once
          if (!scan_en_r[ch_r]) begin
            conv_connect <= 1'b0;
            state_r <= ST_IDLE;
          end else if (tick) begin
            conv_sample <= 1'b1;
            ones_r <= ones_r + {11'h000, conv_bit};
            nsamp_r <= nsamp_r + 12'h001;
            // a rate lowered mid-conversion must not overshoot the end
            if (nsamp_r >= last_samp) begin
              conv_connect <= 1'b0;
              state_r <= ST_STORE;
            end
          end
        end
        ST_STORE: begin
          result_r[ch_r] <= avg - base_r[ch_r];
          upd_r[ch_r] <= 1'b1;
          nsamp_r <= 12'h000;
          ones_r <= 12'h000;
          if (scan_en_r != 8'h00) begin
            ch_r <= next_ch(scan_en_r, ch_r);
            conv_chan_sel <= next_ch(scan_en_r, ch_r);
            conv_connect <= 1'b1;
            state_r <= ST_CONV;
          end else begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          conv_connect <= 1'b0;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // one decision block per input, strobed on the same edge its result lands
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : chan
      touch_channel_decide u_dec (
        .clk(clk),
        .arst_n(arst_n),
        .update(upd_r[g]),
        .delta(result_r[g]),
        .thresh(thresh_r),
        .margin(margin_r),
        .touched_r(touched[g]),
        .ev_touch_r(ev_t[g]),
        .ev_untouch_r(ev_u[g])
      );
    end
  endgenerate

  // slider or wheel location with 2x interpolation
  always @* begin
    loc = 5'h00;
    cnt = 4'h0;
    found = 1'b0;
    cand = 1'b0;
    prev_t = 1'b0;
    first_t = 1'b0;
    for (i = 0; i < NCH; i = i + 1) begin
      if (slider_assign_r[i]) begin
        if (cnt == 4'h0)
          first_t = touched[i];
        if (touched[i] && !found && !cand) begin
          if (prev_t) begin
            loc = {cnt, 1'b0} - 5'h01;
            found = 1'b1;
          end else begin
            loc = {cnt, 1'b0};
            cand = 1'b1;
          end
        end else if (touched[i] && cand && !found) begin
          loc = loc + 5'h01;
          found = 1'b1;
        end else if (!touched[i] && cand) begin
          found = 1'b1;
        end
        prev_t = touched[i];
        cnt = cnt + 4'h1;
      end
    end
    // a wheel closes: last and first elements give position 2n-1
    if (slider_assign_r[`SLIDER_WHEEL_BIT] && first_t && prev_t &&
        cnt > 4'h1 && loc == 5'h00)
      loc = {cnt, 1'b0} - 5'h01;
    any_sl = |(touched & slider_assign_r[7:0]);
  end

  // gpio trigger condition; level triggers hold while the level stays
  always @* begin
    gpio_cond = 1'b0;
    gpio_edge = 1'b0;
    if (gpio_cfg_r[1:0] == `GPIO_FUNC_INPUT) begin
      case (trig)
        `GPIO_TRIG_LOW: gpio_cond = !gpio_in;
        `GPIO_TRIG_HIGH: gpio_cond = gpio_in;
        `GPIO_TRIG_FALL: gpio_edge = gpio_prev_r && !gpio_in;
        `GPIO_TRIG_RISE: gpio_edge = !gpio_prev_r && gpio_in;
        `GPIO_TRIG_BOTH: gpio_edge = gpio_prev_r != gpio_in;
        default: gpio_cond = 1'b0;
      endcase
    end
  end

  // gpio pin driver: disabled and input leave the pin undriven
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gpio_out <= 1'b0;
      gpio_oe <= 1'b0;
      gpio_prev_r <= 1'b0;
    end else begin
      gpio_prev_r <= gpio_in;
      gpio_out <= gpio_cfg_r[1:0] == `GPIO_FUNC_OUT_HIGH;
      gpio_oe <= gpio_cfg_r[1];
    end
  end

  // event flags: a new event in the read cycle survives the clear
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      touch_stat_r <= 8'h00;
      touch_pend_r <= 1'b0;
      slider_flag_r <= 1'b0;
      gpio_flag_r <= 1'b0;
      loc_r <= 5'h00;
      dir_r <= 1'b0;
      any_r <= 1'b0;
    end else begin
      for (fi = 0; fi < NCH; fi = fi + 1) begin
        if (ev_t[fi])
          touch_stat_r[fi] <= 1'b1;
        else if (ev_u[fi])
          touch_stat_r[fi] <= 1'b0;
      end
      touch_pend_r <= (touch_pend_r && !rd_fire) || (|ev_any);
      any_r <= any_sl;
      if (any_sl) begin
        loc_r <= loc;
        if (loc != loc_r && any_r)
          dir_r <= loc > loc_r;
      end
      slider_flag_r <= (slider_flag_r && !rd_fire) ||
                       (any_sl && (!any_r || loc != loc_r)) ||
                       (any_r && !any_sl);
      // a level trigger still present keeps the flag through a read
      gpio_flag_r <= (gpio_flag_r && !(rd_fire && !gpio_cond)) ||
                     gpio_cond || gpio_edge;
    end
  end

  // polarity strap caught at the first edge after reset release
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      inv_r <= 1'b0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      inv_r <= notify_invert_strap;
      strap_done_r <= 1'b1;
    end
  end

  // pin follows the flags, so it moves one edge after they update
  assign notify_active = touch_pend_r || slider_flag_r || gpio_flag_r;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      event_notify_pin <= 1'b1;
    else
      event_notify_pin <= inv_r ? notify_active : !notify_active;
  end

  // register writes, taken at the edge that completes the transfer
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_r <= 1'b0;
      gpio_cfg_r <= `GPIO_CFG_RST;
      scan_en_r <= `SCAN_EN_RST;
      dec_sel_r <= `DEC_SEL_RST;
      thresh_r <= `TOUCH_THRESH_RST;
      margin_r <= `RELEASE_MARGIN_RST;
      slider_assign_r <= `SLIDER_ASSIGN_RST;
      for (bi = 0; bi < NCH; bi = bi + 1)
        base_r[bi] <= `BASELINE_RST;
    end else begin
      ack_r <= (avs_read || avs_write) && !ack_r;
      if (wr_fire) begin
        case (idx)
          `GPIO_CFG_IDX: gpio_cfg_r <=
            merge16(gpio_cfg_r, avs_writedata, avs_byteenable) & 16'h001F;
          `SCAN_CTRL_IDX: begin
            if (avs_byteenable[0])
              scan_en_r <= avs_writedata[7:0];
            if (avs_byteenable[1])
              dec_sel_r <= avs_writedata[`SCAN_DEC_LSB+2:`SCAN_DEC_LSB];
          end
          `TOUCH_THRESH_IDX: thresh_r <=
            merge16(thresh_r, avs_writedata, avs_byteenable);
          `SLIDER_ASSIGN_IDX: begin
            if (avs_byteenable[0])
              slider_assign_r[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1])
              slider_assign_r[8] <= avs_writedata[`SLIDER_WHEEL_BIT];
          end
          `RELEASE_MARGIN_IDX: begin
            if (avs_byteenable[0])
              margin_r <= avs_writedata[5:0];
          end
          default: begin
            if (idx[7:3] == `BASELINE_IDX_HI)
              base_r[idx[2:0]] <=
                merge16(base_r[idx[2:0]], avs_writedata, avs_byteenable);
          end
        endcase
      end
    end
  end

  // read data registered in the wait cycle; unmapped words read zero
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !ack_r) begin
      case (idx)
        `GPIO_CFG_IDX: avs_readdata <= {16'h0000, gpio_cfg_r};
        `EVENT_FLAGS_IDX: avs_readdata <= {16'h0000, gpio_flag_r,
          6'h00, slider_flag_r, touch_stat_r};
        `SLIDER_POS_IDX: avs_readdata <= {25'h0000000, any_r, dir_r,
          loc_r};
        `SLIDER_ASSIGN_IDX: avs_readdata <= {23'h000000,
          slider_assign_r};
        `RELEASE_MARGIN_IDX: avs_readdata <= {26'h0000000, margin_r};
        `SCAN_CTRL_IDX: avs_readdata <= {21'h000000, dec_sel_r,
          scan_en_r};
        `TOUCH_THRESH_IDX: avs_readdata <= {16'h0000, thresh_r};
        default: begin
          if (idx[7:3] == `BASELINE_IDX_HI)
            avs_readdata <= {16'h0000, base_r[idx[2:0]]};
          else if (idx[7:3] == `RESULT_IDX_HI)
            avs_readdata <= {16'h0000, result_r[idx[2:0]]};
          else
            avs_readdata <= 32'h00000000;
        end
      endcase
    end
  end
endmodule // touch_sense_result_logic

// >>> hw/touch_regs.vh
// register map, field layout, reset values and timing of the touch block
`ifndef TOUCH_REGS_VH
`define TOUCH_REGS_VH

// register word indexes; byte address is four times the index
`define GPIO_CFG_IDX 8'h09
`define EVENT_FLAGS_IDX 8'h43
`define SLIDER_POS_IDX 8'h45
`define SLIDER_ASSIGN_IDX 8'h74
`define RELEASE_MARGIN_IDX 8'h75
`define SCAN_CTRL_IDX 8'h10
`define TOUCH_THRESH_IDX 8'h11
`define BASELINE_IDX_HI 5'h04
`define RESULT_IDX_HI 5'h06

// gpio function field and trigger field
`define GPIO_FUNC_DISABLED 2'h0
`define GPIO_FUNC_INPUT 2'h1
`define GPIO_FUNC_OUT_LOW 2'h2
`define GPIO_FUNC_OUT_HIGH 2'h3
`define GPIO_TRIG_LSB 2
`define GPIO_TRIG_LOW 3'h1
`define GPIO_TRIG_HIGH 3'h2
`define GPIO_TRIG_FALL 3'h5
`define GPIO_TRIG_RISE 3'h6
`define GPIO_TRIG_BOTH 3'h7

// event flag bits
`define EV_SLIDER_BIT 8
`define EV_GPIO_BIT 15

// slider result and slider assign fields
`define SLIDER_DIR_BIT 5
`define SLIDER_VALID_BIT 6
`define SLIDER_WHEEL_BIT 8

// scan control fields
`define SCAN_DEC_LSB 8

// decimation select codes: 128,256,512,1024,2048
`define DEC_SEL_2048 3'h4

// reset values
`define GPIO_CFG_RST 16'h0002
`define SCAN_EN_RST 8'hFF
`define DEC_SEL_RST 3'h3
`define TOUCH_THRESH_RST 16'h0040
`define RELEASE_MARGIN_RST 6'h08
`define SLIDER_ASSIGN_RST 9'h000
`define BASELINE_RST 16'h0400

// one converter sample every 2 us gives 0.256 ms at 128 samples
`define SAMPLE_PERIOD_NS 2000
`define CLK_PERIOD_NS 40
`define SAMPLE_CYCLES (`SAMPLE_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// >>> hw/touch_channel_decide.v
// per-channel touch and untouch decision with release margin
`timescale 1ns/1ps
module touch_channel_decide (
  input wire clk,
  input wire arst_n,
  input wire update,
  input wire signed [15:0] delta,
  input wire signed [15:0] thresh,
  input wire [5:0] margin,
  output reg touched_r,
  output reg ev_touch_r,
  output reg ev_untouch_r
);
  wire signed [16:0] untouch_lvl;
  wire above_touch;
  wire below_untouch;

  // widened so a low threshold minus margin cannot wrap
  assign untouch_lvl = {thresh[15], thresh} - {11'h000, margin};
  assign above_touch = delta >= thresh;
  assign below_untouch = $signed({delta[15], delta}) < untouch_lvl;

  // events fire only on a change of state, the gap band holds the state
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      touched_r <= 1'b0;
      ev_touch_r <= 1'b0;
      ev_untouch_r <= 1'b0;
    end else begin
      ev_touch_r <= update && !touched_r && above_touch;
      ev_untouch_r <= update && touched_r && below_untouch;
      if (update && !touched_r && above_touch)
        touched_r <= 1'b1;
      else if (update && touched_r && below_untouch)
        touched_r <= 1'b0;
    end
  end
endmodule // touch_channel_decide

// >>> tb/touch_sense_chk.sv
// port-level assertion checker for the touch scan block
`timescale 1ns/1ps
`include "touch_regs.vh"
module touch_sense_chk #(
  parameter NCH = 8,
  parameter SAMPLE_CYCLES = `SAMPLE_CYCLES
) (
  input wire clk,
  input wire arst_n,
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [2:0] conv_chan_sel,
  input wire conv_connect,
  input wire conv_sample,
  input wire conv_bit,
  input wire notify_invert_strap,
  input wire event_notify_pin,
  input wire gpio_in,
  input wire gpio_out,
  input wire gpio_oe
);
  reg pol_r;
  reg [1:0] age_r;
  wire act;
  wire rd_done;
  // own copy of the strap; age masks the pin settling after reset
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      age_r <= 2'h0;
      pol_r <= 1'b0;
    end else begin
      if (age_r == 2'h0)
        pol_r <= notify_invert_strap;
      if (age_r != 2'h3)
        age_r <= age_r + 2'h1;
    end
  end
  // act is high while the pin shows its active level
  assign act = (event_notify_pin == pol_r);
  assign rd_done = avs_read && !avs_waitrequest &&
    (avs_address[9:2] == `EVENT_FLAGS_IDX);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_WAIT_IDLE: assert property (!(avs_read || avs_write) |->
    !avs_waitrequest)
    else $error("waitrequest high while idle");
  AST_WAIT_RISE: assert property ($rose(avs_read) |-> avs_waitrequest)
    else $error("read answered without wait state");
  AST_WAIT_ONE: assert property ((avs_read || avs_write) &&
    avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  AST_RDATA_STABLE: assert property (!avs_read |=>
    $stable(avs_readdata))
    else $error("read data moved without a read");
  AST_CONN_STABLE: assert property (conv_connect ##1 conv_connect
    |-> $stable(conv_chan_sel))
    else $error("channel changed during conversion");
  AST_SAMPLE_PULSE: assert property (conv_sample |=> !conv_sample)
    else $error("sample pulse too long");
  AST_SAMPLE_CONN: assert property (conv_sample |-> $past(conv_connect))
    else $error("sample taken while not connected");
  AST_GPIO_DRIVE: assert property (gpio_out |-> gpio_oe)
    else $error("gpio high level without drive");
  AST_PIN_RELEASE: assert property ($fell(act) && age_r == 2'h3
    |-> $past(rd_done) || $past(rd_done, 2))
    else $error("pin released without status read");
endmodule // touch_sense_chk
bind touch_sense_result_logic touch_sense_chk #(.NCH(NCH),
  .SAMPLE_CYCLES(SAMPLE_CYCLES)) touch_sense_chk_inst (.clk(clk),
  .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .conv_chan_sel(conv_chan_sel),
  .conv_connect(conv_connect), .conv_sample(conv_sample),
  .conv_bit(conv_bit), .notify_invert_strap(notify_invert_strap),
  .event_notify_pin(event_notify_pin), .gpio_in(gpio_in),
  .gpio_out(gpio_out), .gpio_oe(gpio_oe));

// >>> tb/sigma_delta_source.sv
// behavioural converter: gives ones_cnt ones per conversion
`timescale 1ns/1ps
module sigma_delta_source (
  input wire clk,
  input wire arst_n,
  input wire [2:0] conv_chan_sel,
  input wire conv_connect,
  input wire conv_sample,
  input wire [11:0] ones_cnt,
  input wire clr_used,
  output wire conv_bit,
  output reg [11:0] last_len,
  output reg [7:0] used_mask
);
  reg [11:0] k_r;
  reg idle_r;
  // unconnected output toggles so a stray sample is never a clean value
  assign conv_bit = conv_connect ? (k_r < ones_cnt) : idle_r;
  // count samples per conversion and note every connected channel
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      k_r <= 12'h000;
      idle_r <= 1'b0;
      last_len <= 12'h000;
      used_mask <= 8'h00;
    end else begin
      idle_r <= ~idle_r;
      k_r <= conv_connect ? k_r + {11'h000, conv_sample} : 12'h000;
      if (!conv_connect && k_r != 12'h000)
        last_len <= k_r + {11'h000, conv_sample};
      if (clr_used)
        used_mask <= 8'h00;
      else if (conv_connect)
        used_mask[conv_chan_sel] <= 1'b1;
    end
  end
endmodule // sigma_delta_source

// >>> tb/tb_touch_sense_result_logic.sv
// self-checking bench for the touch scan block
`timescale 1ns/1ps
`include "touch_regs.vh"
module tb_touch_sense_result_logic;
  reg clk, arst_n, avs_read, avs_write, strap, gpio_in, clr_used;
  reg [9:0] avs_address;
  reg [31:0] avs_writedata;
  reg [11:0] ones;
  wire [31:0] avs_readdata;
  wire [11:0] last_len;
  wire [7:0] used_mask;
  wire [2:0] chan;
  wire avs_waitrequest, conv_connect, conv_sample, conv_bit;
  wire event_notify_pin, gpio_out, gpio_oe;
  integer n_errors, n_checks, cyc, i;
  reg [15:0] rd;
  touch_sense_result_logic #(.NCH(8), .SAMPLE_CYCLES(2))
    touch_sense_result_logic_inst (.clk(clk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'h3), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .conv_chan_sel(chan),
    .conv_connect(conv_connect), .conv_sample(conv_sample),
    .conv_bit(conv_bit), .notify_invert_strap(strap),
    .event_notify_pin(event_notify_pin), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe));
  sigma_delta_source sigma_delta_source_inst (.clk(clk), .arst_n(arst_n),
    .conv_chan_sel(chan), .conv_connect(conv_connect),
    .conv_sample(conv_sample), .ones_cnt(ones), .clr_used(clr_used),
    .conv_bit(conv_bit), .last_len(last_len), .used_mask(used_mask));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task results;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // hang guard, well above the longest expected run
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 80000) begin
      n_errors = n_errors + 1;
      results;
    end
  end
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("mismatch %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // one bus transfer; called mid-cycle, returns mid-cycle
  task bus(input wr, input [7:0] idx, input [15:0] wd);
    reg w;
    integer n;
    begin
      @(posedge clk);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {16'h0000, wd};
      avs_write <= wr;
      avs_read <= ~wr;
      w = 1'b1;
      n = 0;
      // waitrequest and read data are taken at the rising edge itself
      while (w && n < 50) begin
        @(posedge clk);
        w = (avs_waitrequest !== 1'b0);
        rd = avs_readdata[15:0];
        n = n + 1;
      end
      chk("bus answer", 16'h0000, {15'h0000, w});
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(negedge clk);
    end
  endtask
  task rdchk(input string nm, input [7:0] idx, input [15:0] m,
    input [15:0] e);
    begin
      bus(1'b0, idx, 16'h0000);
      chk(nm, e, rd & m);
    end
  endtask
  task wait_pin(input lvl, input integer lim);
    integer n;
    begin
      n = 0;
      while (event_notify_pin !== lvl && n < lim) begin
        @(negedge clk);
        n = n + 1;
      end
      chk("event_notify_pin", {15'h0000, lvl}, {15'h0000, event_notify_pin});
    end
  endtask
  // wait out the running conversion and one full one after it
  task conv_end;
    integer n;
    begin
      n = 0;
      repeat (2) begin
        while (conv_connect !== 1'b1 && n < 20000) begin
          @(negedge clk);
          n = n + 1;
        end
        while (conv_connect !== 1'b0 && n < 20000) begin
          @(negedge clk);
          n = n + 1;
        end
      end
      tick(2);
    end
  endtask
  initial begin
    n_errors = 0;
    n_checks = 0;
    cyc = 0;
    arst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 10'h000;
    avs_writedata = 32'h00000000;
    strap = 1'b0;
    gpio_in = 1'b0;
    clr_used = 1'b0;
    ones = 12'h000;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    tick(3);
    // reset state of pins and registers
    chk("gpio_oe", 16'h0001, {15'h0000, gpio_oe});
    chk("gpio_out", 16'h0000, {15'h0000, gpio_out});
    chk("pin idle", 16'h0001, {15'h0000, event_notify_pin});
    rdchk("gpio cfg", `GPIO_CFG_IDX, 16'hFFFF, 16'h0002);
    rdchk("margin", `RELEASE_MARGIN_IDX, 16'h003F, 16'h0008);
    rdchk("assign", `SLIDER_ASSIGN_IDX, 16'hFFFF, 16'h0000);
    rdchk("unmapped", 8'hFF, 16'hFFFF, 16'h0000);
    // every decimation code on channel 0 alone
    for (i = 0; i < 5; i = i + 1) begin
      bus(1'b1, `SCAN_CTRL_IDX, {5'h00, i[2:0], 8'h01});
      conv_end;
      chk("samples", 16'h0080 << i, {4'h0, last_len});
    end
    // touch, gap band, then untouch by narrowing the margin
    bus(1'b1, `SCAN_CTRL_IDX, 16'h0002);
    bus(1'b1, `TOUCH_THRESH_IDX, 16'h0048);
    @(posedge clk) clr_used <= 1'b1;
    @(posedge clk) clr_used <= 1'b0;
    ones = 12'h080;
    wait_pin(1'b0, 3000);
    rdchk("flags touch", `EVENT_FLAGS_IDX, 16'hFFFF, 16'h0002);
    wait_pin(1'b1, 4);
    ones = 12'h044;
    tick(1000);
    chk("pin gap", 16'h0001, {15'h0000, event_notify_pin});
    rdchk("result", `RESULT_IDX_HI * 8 + 1, 16'hFFFF, 16'h0040);
    rdchk("flags held", `EVENT_FLAGS_IDX, 16'hFFFF, 16'h0002);
    bus(1'b1, `RELEASE_MARGIN_IDX, 16'h0004);
    wait_pin(1'b0, 3000);
    rdchk("flags untouch", `EVENT_FLAGS_IDX, 16'hFFFF, 16'h0000);
    wait_pin(1'b1, 4);
    tick(1000);
    chk("pin quiet", 16'h0001, {15'h0000, event_notify_pin});
    chk("used", 16'h0002, {8'h00, used_mask});
    // gpio pin drive under all four functions
    for (i = 0; i < 4; i = i + 1) begin
      bus(1'b1, `GPIO_CFG_IDX, {14'h0000, i[1:0]});
      tick(2);
      // input function leaves the pin undriven, only outputs drive
      chk("oe", {15'h0000, i[1]}, {15'h0000, gpio_oe});
      chk("out", {15'h0000, i == 3}, {15'h0000, gpio_out});
    end
    // rising edge trigger then high level trigger
    bus(1'b1, `GPIO_CFG_IDX, 16'h0019);
    @(posedge clk) gpio_in <= 1'b1;
    wait_pin(1'b0, 10);
    rdchk("flags gpio", `EVENT_FLAGS_IDX, 16'h80FF, 16'h8000);
    wait_pin(1'b1, 4);
    bus(1'b1, `GPIO_CFG_IDX, 16'h0009);
    wait_pin(1'b0, 10);
    rdchk("flags level", `EVENT_FLAGS_IDX, 16'h8000, 16'h8000);
    tick(4);
    chk("pin level", 16'h0000, {15'h0000, event_notify_pin});
    @(posedge clk) gpio_in <= 1'b0;
    tick(2);
    bus(1'b0, `EVENT_FLAGS_IDX, 16'h0000);
    wait_pin(1'b1, 6);
    // two adjacent slider elements touched
    bus(1'b1, `GPIO_CFG_IDX, 16'h0000);
    bus(1'b1, `SLIDER_ASSIGN_IDX, 16'h0003);
    bus(1'b1, `SCAN_CTRL_IDX, 16'h0003);
    ones = 12'h080;
    wait_pin(1'b0, 3000);
    tick(1200);
    rdchk("location", `SLIDER_POS_IDX, 16'h005F, 16'h0041);
    rdchk("flags slider", `EVENT_FLAGS_IDX, 16'h81FF, 16'h0103);
    // inverted pin polarity after a reset with the strap set
    ones = 12'h000;
    @(posedge clk) arst_n <= 1'b0;
    @(posedge clk) strap <= 1'b1;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    tick(3);
    chk("pin inv idle", 16'h0000, {15'h0000, event_notify_pin});
    bus(1'b1, `SCAN_CTRL_IDX, 16'h0002);
    ones = 12'h080;
    wait_pin(1'b1, 3000);
    results;
  end
endmodule // tb_touch_sense_result_logic
